// ### hw/spi_mem_pkg.sv
// constants and types shared by both ends of the serial memory link
// Summary of operation
// [RULE1] master sends write-enable frame before each write; host sends it only on command, bench omits it before the write at 1feh
// [RULE2] write opcode holds address bit 8, byte follows
// [RULE3] write address increments, wraps 1ffh to 000h
// [RULE4] each byte committed at eighth bit, unlimited length
// [RULE5] chip select rising ends write, partial byte dropped
// [RULE6] write protect acts from next byte boundary
// [RULE7] read opcode holds address bit 8, byte follows
// [RULE8] serial input ignored after read address
// [RULE9] read shifts msb first, increments, wraps
// [RULE10] chip select rising ends read, output stops
// [RULE11] hold low with clock low freezes transaction
// [RULE12] hold high with clock low resumes transaction
// [RULE13] hold changes only with clock low; edges ignored
// [RULE14] opcodes 06h, 0000a011b read, 0000a010b write
// [RULE15] writes need latch set; latch clears after write
// [RULE16] protect pin low blocks all; block bits limit
// [RULE17] sample on rising, drive on falling, modes 0/3
// [RULE18] output released unless read data phase
// [RULE19] one opcode per frame; unknown ones ignored
package spi_mem_pkg;

    // =====================================================================
    // array geometry
    localparam int         ADDR_W     = 9;
    localparam int         MEM_DEPTH  = 512;
    localparam int         BYTE_W     = 8;
    localparam int         FIFO_DEPTH = 8;
    localparam int         LEN_W      = 16;

    // =====================================================================
    // opcodes
    localparam logic [7:0] OPC_SET_WRITE_LATCH = 8'h06;
    localparam logic [2:0] OPC_READ_TAIL       = 3'h3;
    localparam logic [2:0] OPC_WRITE_TAIL      = 3'h2;
    localparam logic [3:0] OPC_HEAD            = 4'h0;
    localparam int         OPC_A8_POS          = 3;

    // =====================================================================
    // block protection
    localparam logic [1:0] BP_QUARTER         = 2'h1;
    localparam logic [1:0] BP_HALF            = 2'h2;
    localparam logic [1:0] BP_ALL             = 2'h3;
    localparam logic [8:0] PROT_QUARTER_BASE  = 9'h180;
    localparam logic [8:0] PROT_HALF_BASE     = 9'h100;

    // =====================================================================
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_SCK_MIN_NS  = 50;
    localparam int T_DESELECT_NS = 60;
    localparam int SCK_HALF_CYC  = (T_SCK_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DESELECT_CYC  = (T_DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // =====================================================================
    // host commands
    typedef enum logic [1:0] {
        HOST_OP_SET_WRITE_LATCH_CMD  = 2'h0,
        HOST_OP_WRITE = 2'h1,
        HOST_OP_READ  = 2'h2
    } host_op_e;

endpackage

// ### hw/spi_mem_if.sv
// serial memory link wires between master and memory
`timescale 1ns/1ps
interface spi_mem_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic wp_n;
    logic hold_n;
    logic miso_line;

    // released output line reads as pulled up
    assign miso_line = miso_oe ? miso : 1'b1;

    modport dev (
        input  cs_n,
        input  sck,
        input  mosi,
        input  wp_n,
        input  hold_n,
        output miso,
        output miso_oe
    );

    modport host (
        output cs_n,
        output sck,
        output mosi,
        output wp_n,
        output hold_n,
        input  miso_line
    );
endinterface

// ### hw/spi_mem_host.sv
// master end of the serial memory link with its write data fifo
`timescale 1ns/1ps
module spi_mem_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_in_data,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    output logic      [WIDTH-1:0] o_out_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
        logic          in_ready;
    } fifo_regs_s;

    localparam fifo_regs_s FIFO_RESET = '{wr_ptr: '0, rd_ptr: '0, count: '0, in_ready: 1'b1};

    fifo_regs_s       r;
    fifo_regs_s       next_r;
    logic [WIDTH-1:0] store [DEPTH];
    logic             push;
    logic             pop;

    assign push        = i_in_valid & r.in_ready;
    assign pop         = i_out_ready & (r.count != '0);
    assign o_in_ready  = r.in_ready;
    assign o_out_valid = (r.count != '0);
    assign o_out_data  = store[r.rd_ptr];

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.wr_ptr = (r.wr_ptr == PW'(DEPTH - 1)) ? '0 : r.wr_ptr + PW'(1);
        end
        if (pop) begin
            next_r.rd_ptr = (r.rd_ptr == PW'(DEPTH - 1)) ? '0 : r.rd_ptr + PW'(1);
        end
        next_r.count    = r.count + CW'(push) - CW'(pop);
        next_r.in_ready = (next_r.count != CW'(DEPTH));
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            r <= FIFO_RESET;
        end else begin
            r <= next_r;
        end
        if (push) begin
            store[r.wr_ptr] <= i_in_data;
        end
    end
endmodule

module spi_mem_host #(
    parameter int HALF_CYC = spi_mem_pkg::SCK_HALF_CYC,
    parameter int LEN_W    = spi_mem_pkg::LEN_W
) (
    spi_mem_if.host                   link,
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst,
    input  wire logic                 i_cmd_valid,
    input  spi_mem_pkg::host_op_e     i_cmd_op,
    input  wire logic [8:0]           i_cmd_addr,
    input  wire logic [LEN_W-1:0]     i_cmd_len,
    output logic                      o_cmd_ready,
    input  wire logic [7:0]           i_wdata,
    input  wire logic                 i_wvalid,
    output logic                      o_wready,
    output logic [7:0]                o_rdata,
    output logic                      o_rvalid,
    output logic                      o_done,
    input  wire logic                 i_pause,
    input  wire logic                 i_write_protect_n
);
    localparam int IW = LEN_W + 1;

    typedef enum logic [4:0] {
        HS_IDLE = 5'b00001,
        HS_LOAD = 5'b00010,
        HS_LOW  = 5'b00100,
        HS_HIGH = 5'b01000,
        HS_END  = 5'b10000
    } host_state_e;

    typedef struct packed {
        logic [1:0]            miso_sync;
        host_state_e           state;
        spi_mem_pkg::host_op_e op;
        logic [8:0]            addr;
        logic [LEN_W-1:0]      len;
        logic [IW-1:0]         idx;
        logic [7:0]            tx;
        logic [7:0]            rx;
        logic [2:0]            bit_cnt;
        logic [7:0]            cnt;
        logic                  cs_n;
        logic                  sck;
        logic                  mosi;
        logic                  hold_n;
        logic                  wp_n;
        logic [7:0]            rdata;
        logic                  rvalid;
        logic                  cmd_ready;
        logic                  done;
    } host_regs_s;

    localparam host_regs_s HOST_RESET = '{
        miso_sync: 2'h3, state: HS_IDLE, op: spi_mem_pkg::HOST_OP_SET_WRITE_LATCH_CMD, addr: '0,
        len: '0, idx: '0, tx: '0, rx: '0, bit_cnt: '0, cnt: '0, cs_n: 1'b1,
        sck: 1'b0, mosi: 1'b0, hold_n: 1'b1, wp_n: 1'b1, rdata: '0, rvalid: 1'b0,
        cmd_ready: 1'b1, done: 1'b0};

    host_regs_s r;
    host_regs_s next_r;
    logic [7:0] fifo_data;
    logic       fifo_valid;
    logic       fifo_pop;
    logic [IW-1:0] total;

    spi_mem_fifo #(
        .WIDTH (spi_mem_pkg::BYTE_W),
        .DEPTH (spi_mem_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_rst       (i_rst),
        .i_in_data   (i_wdata),
        .i_in_valid  (i_wvalid),
        .o_in_ready  (o_wready),
        .o_out_data  (fifo_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_pop)
    );

    assign total = (r.op == spi_mem_pkg::HOST_OP_SET_WRITE_LATCH_CMD) ? IW'(1) : IW'(r.len) + IW'(2);

    // =====================================================================
    // frame sequencer, mode 0 clock from divider
    always_comb begin
        next_r           = r;
        fifo_pop         = 1'b0;
        next_r.miso_sync = {r.miso_sync[0], link.miso_line};
        next_r.wp_n      = i_write_protect_n;
        next_r.rvalid    = 1'b0;
        next_r.done      = 1'b0;
        // hold pin never moves on the edge that raises the clock
        if (r.state != HS_HIGH && !(r.state == HS_LOW && r.hold_n && r.cnt == '0)) begin
            next_r.hold_n = ~i_pause; // RULE13
        end
        case (r.state)
            HS_IDLE: begin
                if (i_cmd_valid) begin
                    next_r.op        = i_cmd_op; // RULE1
                    next_r.addr      = i_cmd_addr;
                    next_r.len       = i_cmd_len;
                    next_r.idx       = '0;
                    next_r.cs_n      = 1'b0;
                    next_r.cmd_ready = 1'b0;
                    next_r.state     = HS_LOAD;
                end
            end
            HS_LOAD: begin
                if (r.idx == total) begin
                    next_r.cs_n  = 1'b1;
                    next_r.cnt   = 8'(spi_mem_pkg::DESELECT_CYC - 1);
                    next_r.state = HS_END;
                end else if (r.idx == '0) begin
                    case (r.op)
                        spi_mem_pkg::HOST_OP_READ: next_r.tx = {spi_mem_pkg::OPC_HEAD,
                            r.addr[8], spi_mem_pkg::OPC_READ_TAIL}; // RULE7 RULE14
                        spi_mem_pkg::HOST_OP_WRITE: next_r.tx = {spi_mem_pkg::OPC_HEAD,
                            r.addr[8], spi_mem_pkg::OPC_WRITE_TAIL}; // RULE2 RULE14
                        default: next_r.tx = spi_mem_pkg::OPC_SET_WRITE_LATCH;
                    endcase
                    next_r.state = HS_LOW;
                end else if (r.idx == IW'(1)) begin
                    next_r.tx    = r.addr[7:0];
                    next_r.state = HS_LOW;
                end else if (r.op == spi_mem_pkg::HOST_OP_WRITE) begin
                    // empty fifo stalls with the clock held low
                    if (fifo_valid) begin
                        fifo_pop     = 1'b1;
                        next_r.tx    = fifo_data;
                        next_r.state = HS_LOW;
                    end
                end else begin
                    next_r.tx    = 8'h00;
                    next_r.state = HS_LOW;
                end
                next_r.mosi    = next_r.tx[7];
                next_r.bit_cnt = '0;
                next_r.cnt     = 8'(HALF_CYC - 1);
            end
            HS_LOW: begin
                if (r.hold_n) begin
                    if (r.cnt == '0) begin
                        next_r.sck   = 1'b1;
                        next_r.rx    = {r.rx[6:0], r.miso_sync[1]}; // RULE17
                        next_r.cnt   = 8'(HALF_CYC - 1);
                        next_r.state = HS_HIGH;
                    end else begin
                        next_r.cnt = r.cnt - 8'h01;
                    end
                end else begin
                    // full low phase after resume covers the far end's sync delay
                    next_r.cnt = 8'(HALF_CYC - 1);
                end
            end
            HS_HIGH: begin
                if (r.cnt == '0) begin
                    next_r.sck     = 1'b0;
                    next_r.bit_cnt = r.bit_cnt + 3'h1;
                    next_r.tx      = {r.tx[6:0], 1'b0};
                    next_r.mosi    = r.tx[6];
                    next_r.cnt     = 8'(HALF_CYC - 1);
                    next_r.state   = HS_LOW;
                    if (r.bit_cnt == 3'h7) begin
                        next_r.idx   = r.idx + IW'(1);
                        next_r.state = HS_LOAD;
                        if (r.op == spi_mem_pkg::HOST_OP_READ && r.idx > IW'(1)) begin
                            next_r.rdata  = r.rx;
                            next_r.rvalid = 1'b1;
                        end
                    end
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            HS_END: begin
                if (r.cnt == '0) begin
                    next_r.cmd_ready = 1'b1;
                    next_r.done      = 1'b1;
                    next_r.state     = HS_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
            default: next_r = HOST_RESET;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            r <= HOST_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign link.cs_n   = r.cs_n;
    assign link.sck    = r.sck;
    assign link.mosi   = r.mosi;
    assign link.hold_n = r.hold_n;
    assign link.wp_n   = r.wp_n;
    assign o_cmd_ready = r.cmd_ready;
    assign o_rdata     = r.rdata;
    assign o_rvalid    = r.rvalid;
    assign o_done      = r.done;
endmodule

// ### hw/spi_mem_device.sv
// memory end of the serial link: frame decoder, array and read shifter
`timescale 1ns/1ps
module spi_mem_device #(
    parameter int DEPTH = spi_mem_pkg::MEM_DEPTH
) (
    spi_mem_if.dev           link,
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic [1:0]  i_block_protect,
    output logic             o_write_latch_flag,
    output logic             o_frame_active
);

    // =====================================================================
    // state
    typedef enum logic [5:0] {
        DS_IDLE   = 6'b000001,
        DS_OPCODE = 6'b000010,
        DS_ADDR   = 6'b000100,
        DS_WDATA  = 6'b001000,
        DS_RDATA  = 6'b010000,
        DS_IGNORE = 6'b100000
    } dev_state_e;

    typedef struct packed {
        logic [1:0] cs_n_sync;
        logic [1:0] sck_sync;
        logic [1:0] si_sync;
        logic [1:0] hold_n_sync;
        logic [1:0] wp_n_sync;
        logic       sck_prev;
        dev_state_e state;
        logic [2:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] out_byte;
        logic [8:0] addr;
        logic       is_read;
        logic       write_latch;
        logic       wp_n_byte;
        logic       held;
        logic       so;
        logic       so_oe;
        logic       active;
    } dev_regs_s;

    localparam dev_regs_s DEV_RESET = '{
        cs_n_sync:   2'h3,
        sck_sync:    2'h0,
        si_sync:     2'h0,
        hold_n_sync: 2'h3,
        wp_n_sync:   2'h3,
        sck_prev:    1'b0,
        state:       DS_IDLE,
        bit_cnt:     3'h0,
        shift:       8'h00,
        out_byte:    8'h00,
        addr:        9'h000,
        is_read:     1'b0,
        write_latch: 1'b0,
        wp_n_byte:   1'b1,
        held:        1'b0,
        so:          1'b0,
        so_oe:       1'b0,
        active:      1'b0};

    dev_regs_s  r;
    dev_regs_s  next_r;
    logic [7:0] mem [DEPTH];
    logic       mem_we;
    logic [8:0] mem_wa;
    logic [7:0] mem_wd;

    logic       cs_n;
    logic       sck;
    logic       si;
    logic       hold_n;
    logic       wp_n;
    logic       sck_rise;
    logic       sck_fall;
    logic [7:0] rx_byte;
    logic [8:0] next_addr;

    // =====================================================================
    // block protection map
    function automatic logic addr_blocked(input logic [8:0] a, input logic [1:0] bp);
        case (bp)
            spi_mem_pkg::BP_QUARTER: addr_blocked = (a >= spi_mem_pkg::PROT_QUARTER_BASE);
            spi_mem_pkg::BP_HALF:    addr_blocked = (a >= spi_mem_pkg::PROT_HALF_BASE);
            spi_mem_pkg::BP_ALL:     addr_blocked = 1'b1;
            default:                 addr_blocked = 1'b0;
        endcase
    endfunction

    // =====================================================================
    // synchronised pin levels and edges
    assign cs_n      = r.cs_n_sync[1];
    assign sck       = r.sck_sync[1];
    assign si        = r.si_sync[1];
    assign hold_n    = r.hold_n_sync[1];
    assign wp_n      = r.wp_n_sync[1];
    // same edge sense in modes 0 and 3, so no mode latch is needed
    assign sck_rise  = sck & ~r.sck_prev; // RULE17
    assign sck_fall  = ~sck & r.sck_prev;
    assign rx_byte   = {r.shift[6:0], si};
    assign next_addr = r.addr + 9'h001; // RULE3 RULE9

    // =====================================================================
    // frame decoder
    always_comb begin
        next_r             = r;
        mem_we             = 1'b0;
        mem_wa             = r.addr;
        mem_wd             = rx_byte;
        next_r.cs_n_sync   = {r.cs_n_sync[0], link.cs_n};
        next_r.sck_sync    = {r.sck_sync[0], link.sck};
        next_r.si_sync     = {r.si_sync[0], link.mosi};
        next_r.hold_n_sync = {r.hold_n_sync[0], link.hold_n};
        next_r.wp_n_sync   = {r.wp_n_sync[0], link.wp_n};
        // edges are tracked even while held so resume sees no false edge
        next_r.sck_prev    = sck;

        if (cs_n) begin
            // partial byte is simply dropped with the frame
            if (r.state == DS_WDATA) begin
                next_r.write_latch = 1'b0; // RULE5 RULE15
            end
            next_r.state  = DS_IDLE; // RULE10 RULE19
            next_r.held   = 1'b0;
            next_r.so_oe  = 1'b0; // RULE18
            next_r.active = 1'b0;
        end else if (r.state == DS_IDLE) begin
            next_r.state   = DS_OPCODE;
            next_r.bit_cnt = 3'h0;
            next_r.active  = 1'b1;
        end else if (r.held) begin
            if (hold_n && !sck) begin
                next_r.held  = 1'b0; // RULE12
                next_r.so_oe = (r.state == DS_RDATA);
            end
        end else if (!hold_n && !sck) begin
            next_r.held  = 1'b1; // RULE11 RULE13
            next_r.so_oe = 1'b0; // RULE18
        end else if (sck_rise) begin
            next_r.bit_cnt = r.bit_cnt + 3'h1;
            next_r.shift   = rx_byte;
            if (r.bit_cnt == 3'h0) begin
                next_r.wp_n_byte = wp_n; // RULE6
            end
            if (r.bit_cnt == 3'h7) begin
                case (r.state)
                    DS_OPCODE: begin
                        if (rx_byte == spi_mem_pkg::OPC_SET_WRITE_LATCH) begin
                            next_r.write_latch = 1'b1; // RULE14
                            next_r.state       = DS_IGNORE;
                        end else if (rx_byte[7:4] == spi_mem_pkg::OPC_HEAD &&
                                     rx_byte[2:0] == spi_mem_pkg::OPC_READ_TAIL) begin
                            next_r.addr[8] = rx_byte[spi_mem_pkg::OPC_A8_POS]; // RULE7
                            next_r.is_read = 1'b1;
                            next_r.state   = DS_ADDR;
                        end else if (rx_byte[7:4] == spi_mem_pkg::OPC_HEAD &&
                                     rx_byte[2:0] == spi_mem_pkg::OPC_WRITE_TAIL) begin
                            next_r.addr[8] = rx_byte[spi_mem_pkg::OPC_A8_POS]; // RULE2
                            next_r.is_read = 1'b0;
                            next_r.state   = DS_ADDR;
                        end else begin
                            next_r.state = DS_IGNORE; // RULE19
                        end
                    end
                    DS_ADDR: begin
                        next_r.addr[7:0] = rx_byte; // RULE2 RULE7
                        if (r.is_read) begin
                            next_r.out_byte = mem[{r.addr[8], rx_byte}];
                            next_r.state    = DS_RDATA;
                        end else begin
                            next_r.state = DS_WDATA;
                        end
                    end
                    DS_WDATA: begin
                        // byte goes to the array on its eighth edge, no page limit
                        mem_we      = r.write_latch && r.wp_n_byte &&
                                      !addr_blocked(r.addr, i_block_protect); // RULE4 RULE15 RULE16
                        next_r.addr = next_addr; // RULE3
                    end
                    DS_RDATA: begin
                        next_r.addr     = next_addr; // RULE9
                        next_r.out_byte = mem[next_addr];
                    end
                    default: begin
                        next_r.state = r.state;
                    end
                endcase
            end
            if (r.state == DS_RDATA) begin
                next_r.shift = r.shift; // RULE8
            end
        end else if (sck_fall && r.state == DS_RDATA) begin
            next_r.so       = r.out_byte[7]; // RULE9 RULE17
            next_r.out_byte = {r.out_byte[6:0], 1'b0};
            next_r.so_oe    = 1'b1;
        end
    end

    // =====================================================================
    // registers and array
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            r <= DEV_RESET;
        end else begin
            r <= next_r;
        end
    end

    // array has no reset, as a real nonvolatile store keeps its contents
    always_ff @(posedge i_clk_sys) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign link.miso          = r.so;
    assign link.miso_oe       = r.so_oe;
    assign o_write_latch_flag = r.write_latch;
    assign o_frame_active     = r.active;
endmodule

// ### test/spi_mem_checker.sv
// link wire assertions for the serial memory ends
`timescale 1ns/1ps
module spi_mem_checker (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_miso,
    input wire logic i_miso_oe,
    input wire logic i_hold_n
);
    // ==========
    // sck rises in frame, saturating so long reads stay above 16
    logic [4:0] rises;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || i_cs_n) begin
            rises <= 5'h0;
        end else if ($rose(i_sck) && rises != 5'h1f) begin
            rises <= rises + 5'h1;
        end
    end
    // ==========
    // wire properties
    a_sck_high_width: assert property ($rose(i_sck) |-> i_sck [*7])
        else $error("sck");
    a_cs_sck_low: assert property ($changed(i_cs_n) |-> !i_sck)
        else $error("cs");
    a_hold_sck_low: assert property ($changed(i_hold_n) |-> !i_sck)
        else $error("hold");
    a_miso_steady_high: assert property (i_sck [*4] |-> $stable(i_miso))
        else $error("miso");
    a_idle_released: assert property (i_cs_n [*8] |-> !i_miso_oe)
        else $error("idle");
    a_cs_ends_read: assert property ($rose(i_cs_n) |-> ##[1:6] !i_miso_oe)
        else $error("end");
    a_hold_released: assert property (!i_hold_n [*8] |-> !i_miso_oe)
        else $error("held");
    a_oe_after_addr: assert property ($rose(i_miso_oe) |-> rises >= 5'h10)
        else $error("oe");
endmodule

// ### test/spi_serial_memory_access_bench.sv
// bench joining master and memory ends over the serial link
`timescale 1ns/1ps
module spi_serial_memory_access_bench;
    logic i_clk_sys, i_rst, i_cmd_valid, i_wvalid, i_pause, i_write_protect_n, wl;
    logic o_cmd_ready, o_wready, o_rvalid, o_done, o_write_latch_flag, o_frame_active;
    logic [1:0]  i_block_protect;
    logic [8:0]  i_cmd_addr;
    logic [15:0] i_cmd_len;
    logic [7:0]  i_wdata, o_rdata, b;
    logic [7:0]  model [0:511];
    logic [7:0]  exp_q [$];
    spi_mem_pkg::host_op_e i_cmd_op;
    int seed = 15138, failures = 0, check_count = 0, cycles = 0;
    spi_mem_if spi_mem_if_i ();
    spi_mem_host spi_mem_host_i (.link(spi_mem_if_i.host), .i_clk_sys, .i_rst, .i_cmd_valid,
        .i_cmd_op, .i_cmd_addr, .i_cmd_len, .o_cmd_ready, .i_wdata, .i_wvalid, .o_wready,
        .o_rdata, .o_rvalid, .o_done, .i_pause, .i_write_protect_n);
    spi_mem_device spi_mem_device_i (.link(spi_mem_if_i.dev), .i_clk_sys, .i_rst,
        .i_block_protect, .o_write_latch_flag, .o_frame_active);
    spi_mem_checker spi_mem_checker_i (.i_clk_sys, .i_rst, .i_cs_n(spi_mem_if_i.cs_n),
        .i_sck(spi_mem_if_i.sck), .i_miso(spi_mem_if_i.miso), .i_miso_oe(spi_mem_if_i.miso_oe),
        .i_hold_n(spi_mem_if_i.hold_n));
    // ==========
    // tasks
    task automatic wrap_up();
        if (failures == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    function automatic logic prot(input logic [8:0] ad);
        return i_block_protect == 2'h3 || (i_block_protect == 2'h2 && ad >= 9'h100)
            || (i_block_protect == 2'h1 && ad >= 9'h180);
    endfunction
    task automatic cmd(input spi_mem_pkg::host_op_e op, input logic [8:0] a, input logic [15:0] n);
        @(posedge i_clk_sys);
        i_cmd_op <= op;
        i_cmd_addr <= a;
        i_cmd_len <= n;
        i_cmd_valid <= 1'b1;
        @(posedge i_clk_sys);
        i_cmd_valid <= 1'b0;
        repeat (8) @(negedge i_clk_sys);
        chk("active", 8'h1, {7'h0, o_frame_active});
        do @(negedge i_clk_sys); while (o_done !== 1'b1);
        chk("active", 8'h0, {7'h0, o_frame_active});
    endtask
    task automatic set_write_latch_cmd();
        cmd(spi_mem_pkg::HOST_OP_SET_WRITE_LATCH_CMD, 9'h0, 16'h0);
        wl = 1'b1;
        chk("latch", 8'h1, {7'h0, o_write_latch_flag});
    endtask
    task automatic wr(input logic [8:0] a, input logic [15:0] n);
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            if (wl && i_write_protect_n && !prot(a + 9'(i))) model[a + 9'(i)] = b;
            @(posedge i_clk_sys);
            i_wdata <= b;
            i_wvalid <= 1'b1;
            do @(negedge i_clk_sys); while (o_wready !== 1'b1);
        end
        @(posedge i_clk_sys);
        i_wvalid <= 1'b0;
        repeat (2) @(negedge i_clk_sys);
        if (n == 16'h8) chk("full", 8'h0, {7'h0, o_wready});
        cmd(spi_mem_pkg::HOST_OP_WRITE, a, n);
        wl = 1'b0;
        chk("latch", 8'h0, {7'h0, o_write_latch_flag});
        chk("empty", 8'h1, {7'h0, o_wready});
    endtask
    task automatic rd(input logic [8:0] a, input logic [15:0] n);
        for (int i = 0; i < n; i++) exp_q.push_back(model[a + 9'(i)]);
        cmd(spi_mem_pkg::HOST_OP_READ, a, n);
    endtask
    // ==========
    // clock, timeout, read monitor
    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end
    // ceiling well above the few thousand cycles the sequence needs
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end
    always @(negedge i_clk_sys) begin
        if (o_rvalid === 1'b1) chk("rdata", exp_q.pop_front(), o_rdata);
    end
    // ==========
    // sequence
    initial begin
        {i_rst, i_write_protect_n} = 2'h3;
        {i_cmd_valid, i_wvalid, i_pause, i_block_protect, i_cmd_addr, i_cmd_len, i_wdata} = 38'h0;
        i_cmd_op = spi_mem_pkg::HOST_OP_SET_WRITE_LATCH_CMD;
        repeat (4) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        set_write_latch_cmd();
        wr(9'h1fc, 16'h8);
        wr(9'h1fe, 16'h1);
        for (int k = 0; k < 5; k++) begin
            @(posedge i_clk_sys);
            i_block_protect <= k[1:0];
            i_write_protect_n <= k != 4;
            set_write_latch_cmd();
            wr(9'h1ff, 16'h2);
        end
        fork
            rd(9'h1fc, 16'h8);
            begin
                repeat (500) @(posedge i_clk_sys);
                i_pause <= 1'b1;
                repeat (300) @(posedge i_clk_sys);
                i_pause <= 1'b0;
            end
        join
        chk("left", 8'h0, 8'(exp_q.size()));
        wrap_up();
    end
endmodule
